// ### logic/dsp_acc_pkg.sv
// constants, types and register map of the accumulator round and saturate stage
package dsp_acc_pkg;
  localparam int          ACC_W          = 40;
  localparam int          WORD_W         = 16;
  // register byte offsets
  localparam logic [7:0]  CFG_OFS        = 8'h00;
  localparam logic [7:0]  TRAP_OFS       = 8'h04;
  localparam logic [7:0]  FLAG_OFS       = 8'h08;
  localparam logic [7:0]  PTR_OFS        = 8'h0C;
  localparam logic [7:0]  ACCA_LO_OFS    = 8'h10;
  localparam logic [7:0]  ACCA_HI_OFS    = 8'h14;
  localparam logic [7:0]  ACCB_LO_OFS    = 8'h18;
  localparam logic [7:0]  ACCB_HI_OFS    = 8'h1C;
  // core_config_reg fields
  localparam int          RND_STYLE_BIT  = 1;
  localparam int          CLIP_WIDTH_BIT = 4;
  localparam int          STORE_CLIP_BIT = 5;
  localparam int          SECOND_CLIP_BIT = 6;
  localparam int          FIRST_CLIP_BIT = 7;
  localparam logic [7:0]  CFG_RESET      = 8'h20;
  // trap_control_reg fields
  localparam int          FIRST_GTRAP_BIT  = 0;
  localparam int          SECOND_GTRAP_BIT = 1;
  localparam int          WRAP_TRAP_BIT    = 2;
  localparam logic [2:0]  TRAP_RESET     = 3'h0;
  // cpu_flag_reg fields
  localparam int          GUARD0_BIT     = 0;
  localparam int          CLIP0_BIT      = 2;
  localparam int          EITHER_GUARD_BIT = 4;
  localparam int          EITHER_CLIP_BIT  = 5;
  // saturation targets and rounding constants
  localparam logic [39:0] SAT31_POS      = 40'h007FFFFFFF;
  localparam logic [39:0] SAT31_NEG      = 40'hFF80000000;
  localparam logic [39:0] SAT39_POS      = 40'h7FFFFFFFFF;
  localparam logic [39:0] SAT39_NEG      = 40'h8000000000;
  localparam logic [15:0] WORD_MAX_POS   = 16'h7FFF;
  localparam logic [15:0] WORD_MAX_NEG   = 16'h8000;
  localparam logic [15:0] PTR_STEP       = 16'h0002;
  localparam logic [15:0] PTR_RESET      = 16'h0000;
  localparam logic [9:0]  WORD_EXT_ONES  = 10'h3FF;

  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_ACCUM = 2'b01,
    OP_STORE = 2'b10,
    OP_SHIFT = 2'b11
  } op_kind_t;

  typedef struct packed {
    logic        valid;
    op_kind_t    kind;
    logic        tgt;        // 0 first accumulator, 1 second
    logic [39:0] addend;     // accumulate operand
    logic        wbEn;       // write back non-target accumulator
    logic        wbPostInc;  // 1 post-increment memory, 0 pointer direct
    logic        round;      // store: rounded (1) or truncated (0)
    logic        shSrcX;     // shift source is the X bus word
    logic [15:0] xData;      // X bus word, or store address for OP_STORE
    logic [5:0]  shAmt;      // signed: positive right, negative left
    logic        shArith;
  } acc_op_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [15:0] data;
  } xwr_t;
endpackage

// ### logic/dsp_acc_round_sat.sv
// accumulator adder status, saturation, write-back, rounding, store clipping and barrel shifter
// What this block does
// - guard flag follows every adder pass
// - new guard overflow with enable raises trap
// - clip flag sticky, cleared by software only
// - unsaturated: clip flag reports bit 39, traps
// - status shows OR of guard, OR of clip
// - bit 31 mode clips to 1.31 limits
// - bit 31 mode never sets guard flags
// - wrap mode: no clipping, bit 39 sets flag
// - accumulate may store rounded non-target upper word
// - direct write-back loads pointer register itself
// - post-increment write-back stores, pointer plus two
// - round stage gives 16-bit word, style selectable
// - conventional rounding adds accumulator bit 15
// - convergent: exact half rounds on bit 16
// - truncating store truncates, write-back always rounds
// - store clipping never alters source accumulator
// - store clipping forces 0x7FFF or 0x8000
// - store clipping takes sign from bit 39
// - store clipping off passes word unchanged
// - one-cycle 40-bit shifter, accumulator or X source
// - signed amount: positive right, negative left
// - X word placement; 40-bit or 16-bit result
// - config bits 7,6 enable clipping, 4 width
// - guard overflow: bits 39..32 not all equal
`timescale 1ns/1ps
module dsp_acc_round_sat
  import dsp_acc_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // operation request from the core
  input  wire acc_op_t     opIn,
  // results
  output xwr_t             xWr,
  output logic [39:0]      shResult,
  output logic [15:0]      shWord,
  output logic             arithTrap
);
  logic [39:0] acc_ff [2];
  logic [7:0]  cfg_ff;
  logic [2:0]  trap_ff;
  logic [1:0]  guard_ff;
  logic [1:0]  clip_ff;
  logic [15:0] ptr_ff;
  logic [31:0] prdata_ff;
  xwr_t        xWr_ff;
  logic [39:0] shResult_ff;
  logic [15:0] shWord_ff;
  logic        arithTrap_ff;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CFG_OFS) || (a == TRAP_OFS) || (a == FLAG_OFS) || (a == PTR_OFS) ||
             (a == ACCA_LO_OFS) || (a == ACCA_HI_OFS) || (a == ACCB_LO_OFS) || (a == ACCB_HI_OFS);
  endfunction

  // upper word plus round increment, carried out to 25 bits so clipping sees the overflow
  function automatic logic [24:0] roundUp(input logic [39:0] a, input logic doRnd, input logic conv);
    logic inc;
    inc = doRnd & a[15] & (~conv | (a[14:0] != 15'h0000) | a[16]);
    roundUp = {a[39], a[39:16]} + {24'h000000, inc};
  endfunction

  // a negative source rounded up to zero is in range, so the negative test also needs t[24]
  function automatic logic [15:0] storeClip(input logic [24:0] t, input logic sgn, input logic en);
    if (en && !sgn && (t[24:15] != 10'h000))
      storeClip = WORD_MAX_POS;
    else if (en && sgn && t[24] && (t[24:15] != WORD_EXT_ONES))
      storeClip = WORD_MAX_NEG;
    else
      storeClip = t[15:0];
  endfunction

  // configuration decode
  logic        tgt;
  logic        satEn;
  logic        wide;
  logic        convRnd;
  logic        storeClipEn;
  logic [39:0] accTgt;
  logic [39:0] accOther;
  assign tgt         = opIn.tgt;
  assign satEn       = tgt ? cfg_ff[SECOND_CLIP_BIT] : cfg_ff[FIRST_CLIP_BIT];
  assign wide        = cfg_ff[CLIP_WIDTH_BIT];
  assign convRnd     = cfg_ff[RND_STYLE_BIT];
  assign storeClipEn = cfg_ff[STORE_CLIP_BIT];
  assign accTgt      = acc_ff[tgt];
  assign accOther    = acc_ff[~tgt];

  wire logic isAccum = opIn.valid && (opIn.kind == OP_ACCUM);
  wire logic isStore = opIn.valid && (opIn.kind == OP_STORE);
  wire logic isShift = opIn.valid && (opIn.kind == OP_SHIFT);

  // adder pass with saturation
  logic [40:0] sum;
  logic [39:0] res;
  logic        ovf39;
  logic        bit31Ovf;
  logic [39:0] nxt_acc;
  logic        clipEv;
  logic        guardNew;
  always_comb
  begin
    sum      = {accTgt[39], accTgt} + {opIn.addend[39], opIn.addend};
    res      = sum[39:0];
    ovf39    = sum[40] ^ sum[39];
    bit31Ovf = ovf39 | ((|res[39:31]) & ~(&res[39:31]));
    nxt_acc  = res;
    clipEv   = ovf39;
    guardNew = (|res[39:32]) & ~(&res[39:32]);
    if (satEn && !wide)
    begin
      clipEv   = bit31Ovf;
      nxt_acc  = bit31Ovf ? (sum[40] ? SAT31_NEG : SAT31_POS) : res;
      guardNew = 1'b0;
    end
    else if (satEn && wide)
    begin
      nxt_acc  = ovf39 ? (sum[40] ? SAT39_NEG : SAT39_POS) : res;
      guardNew = (|nxt_acc[39:32]) & ~(&nxt_acc[39:32]);
    end
  end

  // apb
  wire logic apbSetup = psel && !penable;
  wire logic apbWr    = psel && penable && pwrite && mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign prdata  = prdata_ff;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      prdata_ff <= 32'h00000000;
    else if (apbSetup)
    begin
      if (paddr == CFG_OFS)
        prdata_ff <= {24'h000000, cfg_ff};
      else if (paddr == TRAP_OFS)
        prdata_ff <= {29'h00000000, trap_ff};
      else if (paddr == FLAG_OFS)
        prdata_ff <= {26'h0000000, |clip_ff, |guard_ff, clip_ff, guard_ff};
      else if (paddr == PTR_OFS)
        prdata_ff <= {16'h0000, ptr_ff};
      else if (paddr == ACCA_LO_OFS)
        prdata_ff <= acc_ff[0][31:0];
      else if (paddr == ACCA_HI_OFS)
        prdata_ff <= {24'h000000, acc_ff[0][39:32]};
      else if (paddr == ACCB_LO_OFS)
        prdata_ff <= acc_ff[1][31:0];
      else if (paddr == ACCB_HI_OFS)
        prdata_ff <= {24'h000000, acc_ff[1][39:32]};
      else
        prdata_ff <= 32'h00000000;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_ff  <= CFG_RESET;
      trap_ff <= TRAP_RESET;
    end
    else if (apbWr && (paddr == CFG_OFS))
      cfg_ff <= pwdata[7:0];
    else if (apbWr && (paddr == TRAP_OFS))
      trap_ff <= pwdata[2:0];
  end

  // accumulators: an adder pass wins over a software write in the same cycle
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : accGen
      localparam logic [7:0] LO_OFS = (g == 0) ? ACCA_LO_OFS : ACCB_LO_OFS;
      localparam logic [7:0] HI_OFS = (g == 0) ? ACCA_HI_OFS : ACCB_HI_OFS;
      localparam logic       ACC_IDX = 1'(g);
      always_ff @(posedge core_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          acc_ff[g]   <= 40'h0000000000;
          guard_ff[g] <= 1'b0;
          clip_ff[g]  <= 1'b0;
        end
        else
        begin
          if (isAccum && (tgt == ACC_IDX))
          begin
            acc_ff[g]   <= nxt_acc;
            guard_ff[g] <= guardNew;
          end
          else if (apbWr && (paddr == LO_OFS))
            acc_ff[g][31:0] <= pwdata;
          else if (apbWr && (paddr == HI_OFS))
            acc_ff[g][39:32] <= pwdata[7:0];
          // write one to clear; a clip event in the same cycle wins
          if (isAccum && (tgt == ACC_IDX) && clipEv)
            clip_ff[g] <= 1'b1;
          else if (apbWr && (paddr == FLAG_OFS) && pwdata[CLIP0_BIT + g])
            clip_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      arithTrap_ff <= 1'b0;
    else
      arithTrap_ff <= isAccum && ((guardNew && trap_ff[tgt ? SECOND_GTRAP_BIT : FIRST_GTRAP_BIT]) ||
                                  (!satEn && ovf39 && trap_ff[WRAP_TRAP_BIT]));
  end
  assign arithTrap = arithTrap_ff;

  // write-back and store
  logic [24:0] wbUp;
  logic [24:0] stUp;
  assign wbUp = roundUp(accOther, 1'b1, convRnd);
  assign stUp = roundUp(accTgt, opIn.round, convRnd);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      ptr_ff <= PTR_RESET;
    else if (isAccum && opIn.wbEn && !opIn.wbPostInc)
      ptr_ff <= wbUp[15:0];
    else if (isAccum && opIn.wbEn)
      ptr_ff <= ptr_ff + PTR_STEP;
    else if (apbWr && (paddr == PTR_OFS))
      ptr_ff <= pwdata[15:0];
  end

  // only the memory word is clipped; the accumulators are not touched here
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      xWr_ff <= '0;
    else if (isAccum && opIn.wbEn && opIn.wbPostInc)
      xWr_ff <= '{valid: 1'b1, addr: ptr_ff, data: storeClip(wbUp, accOther[39], storeClipEn)};
    else if (isStore)
      xWr_ff <= '{valid: 1'b1, addr: opIn.xData, data: storeClip(stUp, accTgt[39], storeClipEn)};
    else
      xWr_ff <= '0;
  end
  assign xWr = xWr_ff;

  // barrel shifter
  logic [39:0] shOp;
  logic [39:0] shNxt;
  logic        shRight;
  logic        xExt;
  logic [5:0]  negAmt;
  always_comb
  begin
    shRight = ~opIn.shAmt[5];
    negAmt  = 6'(-opIn.shAmt);
    xExt    = opIn.shArith & opIn.xData[15];
    if (!opIn.shSrcX)
      shOp = accTgt;
    else if (shRight)
      shOp = {{8{xExt}}, opIn.xData, 16'h0000};
    else
      shOp = {{24{xExt}}, opIn.xData};
    if (!shRight)
      shNxt = shOp << negAmt[4:0];
    else if (opIn.shArith)
      shNxt = 40'($signed(shOp) >>> opIn.shAmt[3:0]);
    else
      shNxt = shOp >> opIn.shAmt[3:0];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shResult_ff <= 40'h0000000000;
      shWord_ff   <= 16'h0000;
    end
    else if (isShift)
    begin
      shResult_ff <= shNxt;
      shWord_ff   <= shRight ? shNxt[31:16] : shNxt[15:0];
    end
  end
  assign shResult = shResult_ff;
  assign shWord   = shWord_ff;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence postIncWb;
    isAccum && opIn.wbEn && opIn.wbPostInc;
  endsequence

  guard_update_a: assert property (isAccum && !tgt && !(satEn && !wide) && guardNew |=> guard_ff[0])
    else $error("guard flag not set after guard overflow");
  guard_trap_a: assert property (isAccum && guardNew && trap_ff[FIRST_GTRAP_BIT] && !tgt |=> arithTrap)
    else $error("guard overflow trap missing");
  clip_sticky_a: assert property (clip_ff[0] && !(apbWr && paddr == FLAG_OFS) |=> clip_ff[0])
    else $error("clip flag cleared by hardware");
  wrap_trap_a: assert property (isAccum && !satEn && ovf39 && trap_ff[WRAP_TRAP_BIT] |=> arithTrap)
    else $error("wrap trap missing");
  either_clip_a: assert property (psel && penable && !pwrite && paddr == FLAG_OFS
                                  |-> prdata[EITHER_CLIP_BIT] == $past(|clip_ff))
    else $error("either clip summary wrong");
  either_guard_a: assert property (psel && penable && !pwrite && paddr == FLAG_OFS
                                   |-> prdata[EITHER_GUARD_BIT] == $past(|guard_ff))
    else $error("either guard summary wrong");
  sat31_pos_a: assert property (isAccum && !tgt && satEn && !wide && bit31Ovf && !sum[40]
                                |=> acc_ff[0] == SAT31_POS && clip_ff[0])
    else $error("bit 31 positive clip wrong");
  sat39_neg_a: assert property (isAccum && !tgt && satEn && wide && ovf39 && sum[40]
                                |=> acc_ff[0] == SAT39_NEG && clip_ff[0])
    else $error("bit 39 negative clip wrong");
  no_guard31_a: assert property (isAccum && !tgt && satEn && !wide |=> !guard_ff[0])
    else $error("guard flag set in bit 31 mode");
  post_inc_a: assert property (postIncWb |=> xWr.valid && xWr.addr == $past(ptr_ff)
                               && ptr_ff == $past(ptr_ff) + PTR_STEP)
    else $error("post-increment write-back wrong");
  trunc_store_a: assert property (isStore && !opIn.round && !storeClipEn
                                  |=> xWr.valid && xWr.data == $past(accTgt[31:16]))
    else $error("truncated store word wrong");
  store_pos_clip_a: assert property (isStore && storeClipEn && !accTgt[39] && accTgt[38:31] != 8'h00
                                     |=> xWr.valid && xWr.data == WORD_MAX_POS)
    else $error("positive store clip wrong");
  store_neg_clip_a: assert property (isStore && storeClipEn && accTgt[39] && accTgt[38:31] != 8'hFF
                                     |=> xWr.valid && xWr.data == WORD_MAX_NEG)
    else $error("negative store clip wrong");
  store_pass_a: assert property (isStore && !storeClipEn && opIn.round && !convRnd
                                 |=> xWr.data == $past(accTgt[31:16]) + 16'($past(accTgt[15])))
    else $error("unclipped rounded store word wrong");
  shift_zero_a: assert property (isShift && !opIn.shSrcX && opIn.shAmt == 6'h00
                                 |=> shResult == $past(accTgt))
    else $error("zero shift changed operand");
endmodule // dsp_acc_round_sat

// ### testbench/dsp_accumulator_round_saturate_tb.sv
// self-checking bench for the accumulator round, saturate and shift stage
`timescale 1ns/1ps
module dsp_accumulator_round_saturate_tb;
  import dsp_acc_pkg::*;
  // design ports
  logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr, arithTrap;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  acc_op_t     opIn;
  xwr_t        xWr;
  logic [39:0] shResult;
  logic [15:0] shWord;
  // model state
  int          n_errors, cmp_count, seed;
  logic [39:0] acc [2];
  logic [7:0]  cfg;
  logic [2:0]  trp;
  logic [1:0]  gf, cf;
  logic [15:0] ptr;

  dsp_acc_round_sat u_dsp_acc_round_sat (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .opIn(opIn), .xWr(xWr), .shResult(shResult), .shWord(shWord), .arithTrap(arithTrap));

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic stop_test;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] re);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    re = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      n_errors++;
      $display("ERROR %0t bus answer timed out", $time);
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] re;
    apb(1'b1, a, d, re);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic [32:0] re;
    apb(1'b0, a, 32'h0, re);
    chk(40'(re), 40'({ee, exp}));
  endtask

  task automatic sacc(input logic t, input logic [39:0] v);
    wr(t ? ACCB_LO_OFS : ACCA_LO_OFS, v[31:0]);
    wr(t ? ACCB_HI_OFS : ACCA_HI_OFS, {24'h0, v[39:32]});
    acc[t] = v;
  endtask

  function automatic logic [39:0] rv();
    logic [31:0] x, y;
    x = $random(seed);
    y = $random(seed);
    return x[0] ? {{8{y[31]}}, y} : {x[15:8], y};
  endfunction

  function automatic int hiw(logic [39:0] a, logic rnd);
    int h;
    h = int'(signed'(a[39:16]));
    if (rnd)
      h += (cfg[RND_STYLE_BIT] && a[15:0] == 16'h8000) ? a[16] : a[15];
    return h;
  endfunction

  function automatic logic [15:0] clp(logic [39:0] a, int h);
    if (cfg[STORE_CLIP_BIT] && !a[39] && h > 32767)
      return WORD_MAX_POS;
    if (cfg[STORE_CLIP_BIT] && a[39] && h < -32768)
      return WORD_MAX_NEG;
    return h[15:0];
  endfunction

  task automatic op(input acc_op_t o);
    logic [39:0] a, nt, r, src;
    longint      s, lim;
    xwr_t        ex;
    logic        tr, ov, ce, b31;
    int          h, sa;
    a = acc[o.tgt];
    nt = acc[!o.tgt];
    ex = '0;
    tr = 1'b0;
    @(posedge core_clk);
    opIn <= o;
    @(posedge core_clk);
    opIn <= '0;
    #1;
    case (o.kind)
      OP_ACCUM:
      begin
        s = longint'(signed'(a)) + longint'(signed'(o.addend));
        ce = cfg[o.tgt ? SECOND_CLIP_BIT : FIRST_CLIP_BIT];
        b31 = ce && !cfg[CLIP_WIDTH_BIT];
        lim = b31 ? 64'sh7FFFFFFF : 64'sh7FFFFFFFFF;
        ov = s > lim || s < -lim - 1;
        r = s[39:0];
        if (ce && ov)
          r = s > 0 ? lim[39:0] : ~lim[39:0];
        acc[o.tgt] = r;
        gf[o.tgt] = !b31 && !(&r[39:32]) && (|r[39:32]);
        cf[o.tgt] = cf[o.tgt] | ov;
        tr = (gf[o.tgt] && trp[o.tgt]) || (!ce && ov && trp[WRAP_TRAP_BIT]);
        if (o.wbEn)
        begin
          h = hiw(nt, 1'b1);
          if (o.wbPostInc)
          begin
            ex = {1'b1, ptr, clp(nt, h)};
            ptr += PTR_STEP;
          end
          else
            ptr = h[15:0];
        end
      end
      OP_STORE: ex = {1'b1, o.xData, clp(a, hiw(a, o.round))};
      OP_SHIFT:
      begin
        sa = int'(signed'(o.shAmt));
        if (o.shSrcX)
          src = sa >= 0 ? {{8{o.shArith & o.xData[15]}}, o.xData, 16'h0} : {{24{o.shArith & o.xData[15]}}, o.xData};
        else
          src = a;
        if (sa > 0 && o.shArith)
          r = signed'(src) >>> sa;
        else if (sa > 0)
          r = src >> sa;
        else
          r = src << (-sa);
        chk(shResult, r);
        chk(40'(shWord), 40'(sa >= 0 ? r[31:16] : r[15:0]));
      end
      default: ;
    endcase
    if (ex.valid)
      chk(40'(xWr), 40'(ex));
    else
      chk(40'(xWr.valid), 40'h0);
    chk(40'(arithTrap), 40'(tr));
    rd(FLAG_OFS, {26'h0, |cf, |gf, cf, gf}, 1'b0);
    rd(PTR_OFS, {16'h0, ptr}, 1'b0);
    rd(o.tgt ? ACCB_LO_OFS : ACCA_LO_OFS, acc[o.tgt][31:0], 1'b0);
    rd(o.tgt ? ACCB_HI_OFS : ACCA_HI_OFS, {24'h0, acc[o.tgt][39:32]}, 1'b0);
  endtask

  initial
  begin
    acc_op_t     o;
    logic [31:0] x, y;
    seed = 52;
    n_errors = 0;
    cmp_count = 0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    opIn = '0;
    acc[0] = '0;
    acc[1] = '0;
    cfg = CFG_RESET;
    trp = TRAP_RESET;
    gf = 2'b00;
    cf = 2'b00;
    ptr = PTR_RESET;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    rd(CFG_OFS, {24'h0, CFG_RESET}, 1'b0);
    rd(TRAP_OFS, 32'h0, 1'b0);
    rd(FLAG_OFS, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    // rounding ties and neighbours under both styles
    for (int i = 0; i < 12; i++)
    begin
      cfg = (i >= 6) ? 8'h22 : 8'h20;
      wr(CFG_OFS, {24'h0, cfg});
      sacc(1'b0, {23'h001234, i[1] ^ i[2], 16'h7FFF + 16'(i % 3)});
      o = '0;
      o.valid = 1'b1;
      o.kind = OP_STORE;
      o.round = 1'b1;
      o.xData = 16'(i * 2);
      op(o);
    end
    repeat (60)
    begin
      x = $random(seed);
      y = $random(seed);
      cfg = x[15:8] & 8'hF2;
      wr(CFG_OFS, {24'h0, cfg});
      trp = x[18:16];
      wr(TRAP_OFS, {29'h0, trp});
      rd(TRAP_OFS, {29'h0, trp}, 1'b0);
      if (x[11])
      begin
        wr(FLAG_OFS, {28'h0, x[13:12], 2'b00});
        cf = cf & ~x[13:12];
      end
      ptr = y[31:16];
      wr(PTR_OFS, {16'h0, ptr});
      sacc(1'b0, rv());
      sacc(1'b1, rv());
      o = '0;
      o.valid = 1'b1;
      o.kind = x[1:0] == 2'b00 ? OP_ACCUM : op_kind_t'(x[1:0]);
      o.tgt = x[2];
      o.addend = rv();
      o.wbEn = x[3];
      o.wbPostInc = x[4];
      o.round = x[5];
      o.shSrcX = x[6];
      o.shArith = x[7];
      o.xData = y[15:0];
      o.shAmt = 6'(int'(y[20:16]) - 16);
      if (o.shSrcX && o.shAmt == 6'h00)
        o.shAmt = 6'h01;
      op(o);
    end
    stop_test();
  end
endmodule // dsp_accumulator_round_saturate_tb
